// >>> dpt_pkg.sv
// shared constants for the dual pwm timer block
package dpt_pkg;
    localparam int unsigned T0_W          = 16;
    localparam int unsigned T2_W          = 14;
    localparam logic [T0_W-1:0] T0_RST    = 16'h0000;
    localparam logic [T2_W-1:0] T2_ZERO   = 14'h0000;
    localparam logic [3:0] DIV10_LAST     = 4'h9;
    // clock choice encoding: 0 = slow 32 khz, 1 = fast gated clock
    localparam logic CLK_SLOW             = 1'b0;
    localparam logic CLK_FAST             = 1'b1;
    // fast divider: 16/8/4/2 mhz from a 16 mhz tick source
    localparam logic [1:0] FDIV_1         = 2'h0;
    localparam logic [1:0] FDIV_2         = 2'h1;
    localparam logic [1:0] FDIV_4         = 2'h2;
    localparam logic [1:0] FDIV_8         = 2'h3;
    localparam logic [2:0] PRE_RST        = 3'h0;
    // read select codes for the counter readback port
    localparam logic [1:0] RD_ON          = 2'h0;
    localparam logic [1:0] RD_HIGH        = 2'h1;
    localparam logic [1:0] RD_LOW         = 2'h2;
endpackage

// >>> dpt_timer.sv
// dual pwm timer: 16-bit dual-phase timer and 14-bit triple pwm timer
// Functional notes
// R01: 16-bit timer, five clocks, slow default
// R02: fast choices need select, gate and divider
// R03: slow clock needs no gate
// R04: divide-by-ten for on-interval counter only
// R05: counters and reloads reset to zero
// R06: run start: interrupt, load both counters
// R07: phase counter alternates high/low shadow reloads
// R08: true output high in high phase; inverse
// R09: clocked mode outputs clock/2 in high
// R10: on counter holds zero; interrupt at low end
// R11: at interrupt reload counters and shadows
// R12: reload writes reach shadows only at cycle end
// R13: interrupt also raised at start-up
// R14: disabled timer held reset except reloads; code also keeps the freeze flag
// R15: reads return live counters
// R16: freeze set/clear ports stop both counters
// R17: 14-bit counter, sysclk divided 1/2/4/8, enabled
// R18: period counter zero sets outputs, reloads
// R19: duty counter clears outputs at match
// R20: software keeps duty not above period
// R21: duty counter restarts at each period reload
`timescale 1ns/1ps
`default_nettype none
module dpt_timer
    import dpt_pkg::*;
(
    // clock and reset
    input  wire logic            sys_clk,
    input  wire logic            nrst,
    // first timer clock sources, single-cycle ticks
    input  wire logic            tick_16m,
    input  wire logic            tick_32k,
    // first timer control
    input  wire logic            first_timer_run,
    input  wire logic            first_timer_clock_choice,
    input  wire logic            on_counter_div10_enable,
    input  wire logic            clocked_output_mode,
    input  wire logic            fast_clock_gate,
    input  wire logic [1:0]      fast_clock_divider,
    input  wire logic            first_timer_freeze_set,
    input  wire logic            first_timer_freeze_clr,
    // reload writes
    input  wire logic            high_phase_reload_wr,
    input  wire logic            low_phase_reload_wr,
    input  wire logic            on_interval_reload_wr,
    input  wire logic [T0_W-1:0] reload_wdata,
    input  wire logic [1:0]      read_sel,
    // first timer outputs
    output logic [T0_W-1:0]      read_data,
    output logic                 period_interrupt,
    output logic                 true_phase_output,
    output logic                 inverted_phase_output,
    output logic                 first_timer_freeze,
    // second timer control
    input  wire logic            tri_output_enable,
    input  wire logic [1:0]      tri_clock_divider,
    input  wire logic [T2_W-1:0] period_value,
    input  wire logic [T2_W-1:0] per_output_duty_value_0,
    input  wire logic [T2_W-1:0] per_output_duty_value_1,
    input  wire logic [T2_W-1:0] per_output_duty_value_2,
    // second timer outputs
    output logic [2:0]           tri_pwm_output
);
    // divide a 16 mhz-rate tick stream by 1/2/4/8 using a free prescaler
    function automatic logic div_tick(input logic t, input logic [1:0] d,
                                      input logic [2:0] c);
        unique case (d)
            FDIV_1: div_tick = t;
            FDIV_2: div_tick = t & (c[0] == 1'b1);
            FDIV_4: div_tick = t & (c[1:0] == 2'h3);
            FDIV_8: div_tick = t & (c == 3'h7);
        endcase
    endfunction

    // ---------------- first timer ----------------
    logic [2:0]      pre_ff;
    logic [T0_W-1:0] rel_hi_ff;
    logic [T0_W-1:0] rel_lo_ff;
    logic [T0_W-1:0] rel_on_ff;
    logic [T0_W-1:0] sh_hi_ff;
    logic [T0_W-1:0] sh_lo_ff;
    logic [T0_W-1:0] phase_down_counter_ff;
    logic [T0_W-1:0] on_cnt_ff;
    logic            toggle_ff;
    logic            started_ff;
    logic            irq_ff;
    logic            half_ff;
    logic            frz_ff;
    logic            pwm_ff;
    logic [3:0]      d10_ff;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pre_ff <= PRE_RST;
        end else if (tick_16m) begin
            pre_ff <= pre_ff + 3'h1;
        end
    end

    // fast path only counts when its gate is open; slow path is ungated
    wire fast_tick = fast_clock_gate                                     // [R02]
                     & div_tick(tick_16m, fast_clock_divider, pre_ff);
    wire sel_tick  = (first_timer_clock_choice == CLK_FAST) ? fast_tick  // [R01]
                     : tick_32k;                                         // [R03]
    wire run       = first_timer_run & ~frz_ff;
    wire step      = run & started_ff & sel_tick;                        // [R16]
    wire on_step   = step & (~on_counter_div10_enable | (d10_ff == DIV10_LAST)); // [R04]
    wire ph_zero   = (phase_down_counter_ff == T0_RST);
    wire on_zero   = (on_cnt_ff == T0_RST);
    wire cyc_end   = step & ph_zero & toggle_ff & on_zero;               // [R10]
    wire ph_flip   = step & ph_zero & ~cyc_end;                          // [R07]
    wire start     = first_timer_run & ~started_ff;                      // [R13]

    // reload registers survive disable
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rel_hi_ff <= T0_RST;                                         // [R05]
            rel_lo_ff <= T0_RST;
            rel_on_ff <= T0_RST;
        end else begin
            if (high_phase_reload_wr) rel_hi_ff <= reload_wdata;         // [R12]
            if (low_phase_reload_wr)  rel_lo_ff <= reload_wdata;
            if (on_interval_reload_wr) rel_on_ff <= reload_wdata;
        end
    end

    // freeze flag: set port wins over clear port
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            frz_ff <= 1'b0;
        end else if (first_timer_freeze_set) begin
            frz_ff <= 1'b1;                                              // [R16]
        end else if (first_timer_freeze_clr) begin
            frz_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            started_ff <= 1'b0;
            toggle_ff  <= 1'b0;
            sh_hi_ff   <= T0_RST;
            sh_lo_ff   <= T0_RST;
            phase_down_counter_ff <= T0_RST;
            on_cnt_ff  <= T0_RST;
            d10_ff     <= 4'h0;
            irq_ff     <= 1'b0;
            half_ff    <= 1'b0;
        end else if (!first_timer_run) begin
            started_ff <= 1'b0;                                          // [R14]
            toggle_ff  <= 1'b0;
            sh_hi_ff   <= T0_RST;
            sh_lo_ff   <= T0_RST;
            phase_down_counter_ff <= T0_RST;
            on_cnt_ff  <= T0_RST;
            d10_ff     <= 4'h0;
            irq_ff     <= 1'b0;
            half_ff    <= 1'b0;
        end else begin
            irq_ff <= start | cyc_end;                                   // [R06]
            if (start || cyc_end) begin
                started_ff <= 1'b1;
                toggle_ff  <= 1'b0;
                sh_hi_ff   <= rel_hi_ff;                                 // [R11]
                sh_lo_ff   <= rel_lo_ff;
                phase_down_counter_ff <= rel_hi_ff;
                on_cnt_ff  <= rel_on_ff;
                d10_ff     <= 4'h0;
                half_ff    <= 1'b0;
            end else if (step) begin
                half_ff <= ~half_ff;
                if (on_counter_div10_enable) begin
                    d10_ff <= (d10_ff == DIV10_LAST) ? 4'h0 : d10_ff + 4'h1;
                end
                if (ph_flip) begin
                    toggle_ff <= ~toggle_ff;                             // [R07]
                    phase_down_counter_ff <= toggle_ff ? sh_hi_ff : sh_lo_ff;
                end else if (!ph_zero) begin
                    phase_down_counter_ff <= phase_down_counter_ff - 16'h0001;
                end
                if (on_step && !on_zero) begin
                    on_cnt_ff <= on_cnt_ff - 16'h0001;                   // [R10]
                end
            end
        end
    end

    // high phase is toggle low after a start; clocked mode swaps in clock/2
    wire hi_phase = started_ff & ~toggle_ff;
    wire pwm_nxt  = hi_phase & (clocked_output_mode ? half_ff : 1'b1);  // [R09]

    wire [T0_W-1:0] rd_nxt = (read_sel == RD_ON) ? on_cnt_ff            // [R15]
                             : phase_down_counter_ff;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pwm_ff <= 1'b0;
        end else begin
            pwm_ff <= first_timer_run & pwm_nxt;                         // [R08]
        end
    end

    // readback is registered, so it trails read_sel by one clock
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            read_data <= T0_RST;
        end else begin
            read_data <= rd_nxt;                                         // [R15]
        end
    end

    assign true_phase_output     = pwm_ff;                               // [R08]
    assign inverted_phase_output = ~pwm_ff;
    assign period_interrupt      = irq_ff;
    assign first_timer_freeze    = frz_ff;

    // ---------------- second timer ----------------
    logic [2:0]      pre2_ff;
    logic [T2_W-1:0] period_down_counter_ff;
    logic [T2_W-1:0] duty_up_counter_ff;
    logic [2:0]      tri_ff;

    // compare against the next duty count so an output stays high for
    // exactly its duty value in steps; a zero duty never lets it rise
    function automatic logic duty_clear(input logic [T2_W-1:0] nxt_count,
                                        input logic [T2_W-1:0] duty);
        duty_clear = (nxt_count == duty) | (duty == T2_ZERO);
    endfunction

    // prescaler restarts on enable so all outputs begin in step
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pre2_ff <= PRE_RST;
        end else begin
            pre2_ff <= tri_output_enable ? pre2_ff + 3'h1 : PRE_RST;
        end
    end

    wire t2_step  = tri_output_enable                                    // [R17]
                    & div_tick(1'b1, tri_clock_divider, pre2_ff);
    wire per_zero = (period_down_counter_ff == T2_ZERO);
    wire per_off  = (period_value == T2_ZERO);
    wire [T2_W-1:0] duty_nxt = duty_up_counter_ff + 14'h0001;
    // duty above period never matches and leaves its output high
    wire [2:0] duty_zero = {per_output_duty_value_2 == T2_ZERO,
                            per_output_duty_value_1 == T2_ZERO,
                            per_output_duty_value_0 == T2_ZERO};
    wire [2:0] duty_hit  = {duty_clear(duty_nxt, per_output_duty_value_2), // [R19]
                            duty_clear(duty_nxt, per_output_duty_value_1),
                            duty_clear(duty_nxt, per_output_duty_value_0)};

    // period counter: counts down, reloads at zero, holds while period is zero
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            period_down_counter_ff <= T2_ZERO;
        end else if (!tri_output_enable) begin
            period_down_counter_ff <= T2_ZERO;
        end else if (t2_step && !per_off) begin
            if (per_zero) begin
                period_down_counter_ff <= period_value;                  // [R18]
            end else begin
                period_down_counter_ff <= period_down_counter_ff - 14'h0001;
            end
        end
    end

    // duty counter: restarts with every period, held clear while period is zero
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            duty_up_counter_ff <= T2_ZERO;
        end else if (!tri_output_enable) begin
            duty_up_counter_ff <= T2_ZERO;                               // [R17]
        end else if (t2_step) begin
            if (per_off || per_zero) begin
                duty_up_counter_ff <= T2_ZERO;                           // [R21]
            end else begin
                duty_up_counter_ff <= duty_nxt;
            end
        end
    end

    // output levels: set at period reload unless duty is zero, cleared at duty match
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tri_ff <= 3'h0;
        end else if (!tri_output_enable) begin
            tri_ff <= 3'h0;
        end else if (t2_step) begin
            if (per_off) begin
                tri_ff <= 3'h0;
            end else if (per_zero) begin
                tri_ff <= ~duty_zero;                                    // [R18]
            end else begin
                tri_ff <= tri_ff & ~duty_hit;                            // [R19]
            end
        end
    end

    assign tri_pwm_output = tri_ff;
endmodule
`default_nettype wire

// >>> dpt_timer_asserts.sv
// concurrent checks on the dual pwm timer ports
`timescale 1ns/1ps
`default_nettype none
module dpt_timer_asserts
    import dpt_pkg::*;
(
    // watched ports
    input wire logic            sys_clk,
    input wire logic            nrst,
    input wire logic            first_timer_run,
    input wire logic            first_timer_freeze_set,
    input wire logic            first_timer_freeze_clr,
    input wire logic [1:0]      read_sel,
    input wire logic [T0_W-1:0] read_data,
    input wire logic            period_interrupt,
    input wire logic            true_phase_output,
    input wire logic            inverted_phase_output,
    input wire logic            first_timer_freeze,
    input wire logic            tri_output_enable,
    input wire logic [T2_W-1:0] per_output_duty_value_0,
    input wire logic [2:0]      tri_pwm_output
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_frozen2;
        first_timer_freeze ##1 first_timer_freeze;
    endsequence
    AST_INV: assert property (inverted_phase_output == !true_phase_output)
        else $error("phase outputs not inverse");
    AST_START: assert property ($rose(first_timer_run) && !first_timer_freeze |=> period_interrupt)
        else $error("no interrupt after start");
    AST_OFF: assert property (!first_timer_run |=> !true_phase_output && !period_interrupt)
        else $error("stopped timer not held");
    AST_FSET: assert property (first_timer_freeze_set |=> first_timer_freeze)
        else $error("freeze not set");
    AST_FCLR: assert property (first_timer_freeze_clr && !first_timer_freeze_set |=> !first_timer_freeze)
        else $error("freeze not cleared");
    AST_FHOLD: assert property (s_frozen2 ##0 $stable(read_sel) && $stable(first_timer_run)
        |=> $stable(read_data))
        else $error("frozen counter moved");
    AST_TOFF: assert property ((!tri_output_enable)[*3] |-> $stable(tri_pwm_output))
        else $error("disabled pwm moved");
    AST_DUTY0: assert property ((per_output_duty_value_0 == T2_ZERO)[*8] ##1 (per_output_duty_value_0 == T2_ZERO) |-> !tri_pwm_output[0])
        else $error("zero duty output high");
endmodule
bind dpt_timer dpt_timer_asserts u_chk (.*);
`default_nettype wire

// >>> dpt_gpio_load.sv
// output pin load that measures high time and period in clocks
`timescale 1ns/1ps
`default_nettype none
module dpt_gpio_load (
    // pin under observation
    input  wire logic        sys_clk,
    input  wire logic        pin,
    // measured lengths, last complete pulse
    output logic      [15:0] hi_len,
    output logic      [15:0] per_len
);
    logic        prev_ff;
    logic [15:0] cnt_ff;
    // a load only listens, so lengths come from edges seen on the pin
    always_ff @(posedge sys_clk) begin
        prev_ff <= pin;
        cnt_ff  <= (pin && !prev_ff) ? 16'h0001 : cnt_ff + 16'h0001;
        if (pin && !prev_ff) per_len <= cnt_ff;
        if (!pin && prev_ff) hi_len <= cnt_ff;
    end
endmodule
`default_nettype wire

// >>> test_dual_pwm_timer_block.sv
// self-checking bench for the dual pwm timer block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH %0t %s", $time, m); end end
module test_dual_pwm_timer_block;
    import dpt_pkg::*;
    typedef struct packed {
        logic choice; logic [1:0] fdiv; logic [1:0] tdiv; logic [13:0] p; logic [13:0] d;
        logic [15:0] phi; logic [15:0] pper; logic [15:0] thi; logic [15:0] tper;
    } dpt_row_s;
    logic sys_clk = 0, nrst = 0, t16 = 0, t32 = 0, run = 0, csel = 0, gate = 0, fs = 0, fc = 0;
    logic mw = 0, nw = 0, ow = 0, ten = 0, od = 0, pm = 0, tpq = 0, irq, tpo, ipo, frz;
    logic [1:0] fdiv = 0, tdiv = 0, rsel = 0;
    logic [2:0] tpwm;
    logic [15:0] wd = 0, rd, v, phi, pper, thi, tper;
    logic [13:0] per = 0, d0 = 0, d12 = 0;
    int mismatches = 0, tests_run = 0, cyc = 0, n;
    dpt_row_s rows [3];
    dpt_timer DUT (.sys_clk(sys_clk), .nrst(nrst), .tick_16m(t16), .tick_32k(t32),
        .first_timer_run(run), .first_timer_clock_choice(csel), .on_counter_div10_enable(od),
        .clocked_output_mode(pm), .fast_clock_gate(gate), .fast_clock_divider(fdiv),
        .first_timer_freeze_set(fs), .first_timer_freeze_clr(fc), .high_phase_reload_wr(mw),
        .low_phase_reload_wr(nw), .on_interval_reload_wr(ow), .reload_wdata(wd),
        .read_sel(rsel), .read_data(rd), .period_interrupt(irq), .true_phase_output(tpo),
        .inverted_phase_output(ipo), .first_timer_freeze(frz), .tri_output_enable(ten),
        .tri_clock_divider(tdiv), .period_value(per), .per_output_duty_value_0(d0),
        .per_output_duty_value_1(d12), .per_output_duty_value_2(d12), .tri_pwm_output(tpwm));
    dpt_gpio_load u_pload (.sys_clk(sys_clk), .pin(tpo), .hi_len(phi), .per_len(pper));
    dpt_gpio_load u_tload (.sys_clk(sys_clk), .pin(tpwm[0]), .hi_len(thi), .per_len(tper));
    initial forever #25 sys_clk = !sys_clk;
    // slow tick every fourth clock keeps slow rows short
    always @(posedge sys_clk) begin
        cyc++;
        t32 <= (cyc % 4 == 0);
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        rows[0] = {1'b1, FDIV_1, 2'h0, 14'd5, 14'd2, 16'd3, 16'd8, 16'd2, 16'd6};
        rows[1] = {1'b1, FDIV_2, 2'h1, 14'd3, 14'd1, 16'd6, 16'd16, 16'd2, 16'd8};
        rows[2] = {CLK_SLOW, FDIV_1, 2'h3, 14'd4, 14'd2, 16'd12, 16'd32, 16'd16, 16'd40};
        step(10);
        nrst <= 1;
        step(1);
        `CHK({irq, tpo, ipo, frz, tpwm, rd}, {4'b0010, 3'h0, T0_RST}, "reset outputs")
        // high phase 2, low phase 4, on interval 0
        wd <= 16'h0002; mw <= 1; step(1); mw <= 0; wd <= 16'h0004; nw <= 1; step(1);
        nw <= 0; wd <= 16'h0000; ow <= 1; step(1); ow <= 0; t16 <= 1; gate <= 1;
        for (int i = 0; i < 3; i++) begin
            run <= 0; ten <= 0; csel <= rows[i].choice; fdiv <= rows[i].fdiv;
            tdiv <= rows[i].tdiv; per <= rows[i].p; d0 <= rows[i].d; d12 <= rows[i].d;
            step(3);
            run <= 1; ten <= 1; n = 0;
            repeat (4) begin @(negedge sys_clk); n += irq; end
            `CHK(n, 1, "start interrupt")
            step(250);
            `CHK({phi, pper}, {rows[i].phi, rows[i].pper}, "phase timing")
            `CHK({thi, tper}, {rows[i].thi, rows[i].tper}, "tri timing")
        end
        fs <= 1; fc <= 1; step(1); fs <= 0; fc <= 0; rsel <= RD_HIGH; step(3);
        `CHK(frz, 1'b1, "freeze set wins")
        v = rd; rsel <= RD_LOW; step(3);
        `CHK(rd, v, "phase counter on both reads")
        fc <= 1; d0 <= T2_ZERO; step(1); fc <= 0; step(200);
        `CHK({frz, phi, pper}, {1'b0, 16'd12, 16'd32}, "resume after freeze")
        `CHK(tpwm[0], 1'b0, "zero duty")
        // on counter tenfold slower while the phase counter keeps full rate
        run <= 0; csel <= CLK_FAST; fdiv <= FDIV_1; wd <= 16'h0001; mw <= 1; nw <= 1; step(1);
        mw <= 0; nw <= 0; wd <= 16'h0003; ow <= 1; step(1);
        ow <= 0; od <= 1; run <= 1; step(20); n = 0;
        repeat (320) begin @(negedge sys_clk); n += irq; end
        `CHK(n, 10, "tenfold on interval")
        `CHK({phi, pper}, {16'd2, 16'd4}, "phase rate kept")
        // clocked high phase: four one-clock pulses per sixteen-step period
        step(1); od <= 0; run <= 0; wd <= 16'h0007; mw <= 1; nw <= 1; step(1);
        mw <= 0; nw <= 0; pm <= 1; run <= 1; step(20); n = 0; tpq = tpo;
        repeat (160) begin @(negedge sys_clk); n += (tpo && !tpq); tpq = tpo; end
        `CHK({n, phi}, {32'd40, 16'd1}, "clocked high phase")
        step(1); pm <= 0;
        run <= 0; step(3);
        `CHK({rd, tpo}, {T0_RST, 1'b0}, "stopped timer")
        tally_and_finish();
    end
endmodule
`default_nettype wire
